// ==== dv/fdcm_search_model.sv ====
`timescale 1ns/1ps
// ****************************************
// ID field source on the search side
// ****************************************
module fdcm_search_model (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Search handshake
    input  wire logic        req_i,
    input  wire logic [3:0]  gap_i,
    input  wire logic [31:0] good_i,
    output logic             valid_o,
    output logic             ok_o,
    output logic [31:0]      chrn_o
);
    logic [4:0] cnt_q;
    always_ff @(posedge clk_i) begin
        valid_o <= 1'b0;
        // Fields outside a pulse carry no meaning, so keep them moving
        ok_o    <= ~ok_o;
        chrn_o  <= ~chrn_o;
        if (!rst_n_i) begin
            cnt_q  <= 5'h00;
            ok_o   <= 1'b0;
            chrn_o <= 32'h0;
        end else if (!req_i) begin
            cnt_q <= 5'h00;
        end else begin
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == {1'b0, gap_i}) begin
                // Damaged field first, must be passed over
                valid_o <= 1'b1;
                ok_o    <= 1'b0;
                chrn_o  <= ~good_i;
            end else if (cnt_q == {1'b0, gap_i} + 5'h08) begin
                valid_o <= 1'b1;
                ok_o    <= 1'b1;
                chrn_o  <= good_i;
            end
        end
    end
endmodule

// ==== dv/fdcm_top_tb.sv ====
`timescale 1ns/1ps
module fdcm_top_tb;
    import fdcm_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic        clk, rst_n, awv, wv, arv, bready, rready, lwf, nd;
    logic [3:0]  awa, ara, step_rate_time, head_unload_time, gap;
    logic [6:0]  head_load_time;
    logic [7:0]  sc, end_of_track, cfg, pre, b[10];
    logic [23:0] st;
    logic [31:0] wd, present_cylinder_number, good, rd_last, r;
    logic [31:0] seed = 32'h7FC63F0C;
    logic [7:0]  bad[4] = '{8'h00, 8'h18, 8'h1F, 8'hFF};
    logic [1:0]  bq[$];
    logic [34:0] rq[$];
    wire logic   awr, wrdy, bv, arr, rv, sreq, mfm, hd, lk, sb, pg, wg;
    wire logic   idv, idok;
    wire logic [1:0]  br, rr, drv;
    wire logic [3:0]  pd;
    wire logic [31:0] rdat, chrn;
    int          num_errors, num_checks, cyc;

    fdcm_top fdcm_top_i (
        .CLOCK_I(clk), .RST_N_I(rst_n),
        .AWVALID_I(awv), .AWREADY_O(awr), .AWADDR_I(awa),
        .WVALID_I(wv), .WREADY_O(wrdy), .WDATA_I(wd), .WSTRB_I(4'hF),
        .BVALID_O(bv), .BREADY_I(bready), .BRESP_O(br),
        .ARVALID_I(arv), .ARREADY_O(arr), .ARADDR_I(ara),
        .RVALID_O(rv), .RREADY_I(rready), .RDATA_O(rdat), .RRESP_O(rr),
        .PRESENT_CYLINDER_NUMBER_I(present_cylinder_number), .STEP_RATE_TIME_I(step_rate_time),
        .HEAD_UNLOAD_TIME_I(head_unload_time), .HEAD_LOAD_TIME_I(head_load_time),
        .PIO_TRANSFER_MODE_I(nd), .SECTORS_PER_CYLINDER_I(sc),
        .END_OF_TRACK_I(end_of_track), .LAST_WAS_FORMAT_I(lwf),
        .CONFIG_BITS_I(cfg), .PRECOMP_START_TRACK_I(pre),
        .SEARCH_REQ_O(sreq), .SEARCH_MFM_O(mfm), .HEAD_SELECT_O(hd),
        .SEARCH_DRIVE_O(drv), .ID_VALID_I(idv), .ID_OK_I(idok),
        .SEARCH_FAIL_I(1'b0), .ID_CHRN_I(chrn), .RESULT_STATUS_I(st),
        .PERP_DRIVES_O(pd), .PERP_GAP_O(pg),
        .WRITE_GATE_EARLY_TIMING_O(wg), .LOCK_O(lk), .STANDBY_O(sb));

    fdcm_search_model fdcm_search_model_i (
        .clk_i(clk), .rst_n_i(rst_n), .req_i(sreq), .gap_i(gap),
        .good_i(good), .valid_o(idv), .ok_o(idok), .chrn_o(chrn));

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [34:0] ex(input logic [7:0] v);
        return {1'b1, RESP_OKAY, 24'h0, v};
    endfunction

    task automatic chk(input string n, input logic [33:0] e,
                       input logic [33:0] s);
        num_checks++;
        if (s !== e) begin
            num_errors++;
            $display("unexpected %s exp %h got %h", n, e, s);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d,
                      input logic [1:0] e = RESP_OKAY);
        logic ad, dd;
        ad = 1'b0;
        dd = 1'b0;
        bq.push_back(e);
        awa <= a;
        wd  <= {24'h0, d};
        awv <= 1'b1;
        wv  <= 1'b1;
        while (!(ad && dd)) begin
            @(posedge clk);
            if (!ad && awr === 1'b1) begin
                ad = 1'b1;
                awv <= 1'b0;
            end
            if (!dd && wrdy === 1'b1) begin
                dd = 1'b1;
                wv <= 1'b0;
            end
        end
        do @(posedge clk); while (bv !== 1'b1);
    endtask

    task automatic rd(input logic [3:0] a, input logic [34:0] e);
        rq.push_back(e);
        ara <= a;
        arv <= 1'b1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        do @(posedge clk); while (rv !== 1'b1);
        rd_last = rdat;
    endtask

    // Result bytes appear only after the load, so wait on status
    task automatic poll_pull(input int n);
        do rd(ADDR_STATUS, 35'h0); while (rd_last[4] !== 1'b1);
        for (int i = 0; i < n; i++) rd(ADDR_DATA, ex(b[i]));
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ****************************************
    // Response watcher and timeout
    // ****************************************
    always @(posedge clk) begin
        logic [34:0] e;
        cyc <= cyc + 1;
        if (bv === 1'b1) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, br});
        if (rv === 1'b1) begin
            e = rq.pop_front();
            if (e[34]) chk("rdata", e[33:0], {rr, rdat});
        end
        if (cyc == 20000) begin
            num_errors++;
            complete_run();
        end
    end

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        {awv, wv, arv, awa, ara, wd, present_cylinder_number, step_rate_time, head_unload_time, head_load_time, nd} = '0;
        {sc, end_of_track, cfg, pre, lwf, gap, good, st} = '0;
        {bready, rready, rst_n} = 3'b110;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(ADDR_STATUS, ex(8'h01));
        rd(ADDR_PERP, ex(8'h00));
        // Drive bits kept matching the drive that software selects
        wr(ADDR_DATA, OP_PERP);
        wr(ADDR_DATA, 8'hB7);
        rd(ADDR_PERP, ex(8'h37));
        chk("perp_drives", 34'(pd), 34'h0D);
        chk("drive_sel", 34'(drv), 34'h0);
        chk("gap_write_gate_early_timing", {32'h0, pg, wg}, 34'h3);
        wr(ADDR_DATA, OP_PERP);
        wr(ADDR_DATA, 8'h02);
        rd(ADDR_PERP, ex(8'h36));
        chk("gap_write_gate_early_timing", {32'h0, pg, wg}, 34'h2);
        for (int l = 0; l < 2; l++) begin
            wr(ADDR_DATA, {l[0], 7'h14});
            b[0] = {3'h0, l[0], 4'h0};
            poll_pull(1);
            chk("lock", 34'(lk), 34'(l[0]));
        end
        wr(ADDR_PERP, 8'h55, RESP_SLVERR);
        rd(ADDR_PERP, ex(8'hB6));
        for (int f = 0; f < 2; f++) begin
            lwf <= ~f[0];
            present_cylinder_number <= rnd();
            r = rnd();
            {step_rate_time, head_unload_time, head_load_time, nd} <= r[15:0];
            {sc, end_of_track, cfg, pre} <= rnd();
            @(posedge clk);
            for (int i = 0; i < 4; i++) b[i] = present_cylinder_number[8*i+:8];
            b[4] = {step_rate_time, head_unload_time};
            b[5] = {head_load_time, nd};
            b[6] = lwf ? sc : end_of_track;
            b[7] = 8'hB6;
            b[8] = {1'b0, cfg[6:0]};
            b[9] = pre;
            wr(ADDR_DATA, OP_DUMP);
            poll_pull(10);
        end
        foreach (bad[i]) begin
            wr(ADDR_DATA, bad[i]);
            b[0] = RES_INVALID;
            poll_pull(1);
            chk("standby", 34'(sb), 34'h1);
        end
        // Opcode owned by another block: no result, standby dropped
        wr(ADDR_DATA, 8'h03);
        rd(ADDR_STATUS, ex(8'h01));
        chk("standby", 34'(sb), 34'h0);
        good <= rnd();
        r = rnd();
        st   <= r[23:0];
        gap  <= r[27:24];
        wr(ADDR_DATA, 8'h4A);
        wr(ADDR_DATA, 8'h06);
        chk("search_sel", {30'h0, mfm, hd, drv}, 34'hE);
        chk("search_req", 34'(sreq), 34'h1);
        for (int i = 0; i < 3; i++) b[i] = st[8*i+:8];
        for (int i = 0; i < 4; i++) b[i+3] = good[8*i+:8];
        poll_pull(7);
        chk("search_req", 34'(sreq), 34'h0);
        // Let the watcher take the last answer before the verdict
        repeat (2) @(posedge clk);
        complete_run();
    end
endmodule

// ==== hw/fdcm_pkg.sv ====
package fdcm_pkg;
    // ********************************************************
    // Register map
    // ********************************************************
    localparam logic [3:0]  ADDR_DATA   = 4'h0;
    localparam logic [3:0]  ADDR_STATUS = 4'h4;
    localparam logic [3:0]  ADDR_PERP   = 4'h8;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    // ********************************************************
    // Opcodes and result constants
    // ********************************************************
    localparam logic [7:0]  OP_DUMP     = 8'h0E;
    localparam logic [4:0]  OP_RDID     = 5'h0A;
    localparam logic [7:0]  OP_PERP     = 8'h12;
    localparam logic [4:0]  OP_LOCK     = 5'h14;
    localparam logic [7:0]  RES_INVALID = 8'h80;
    localparam logic [3:0]  LEN_DUMP    = 4'hA;
    localparam logic [3:0]  LEN_RDID    = 4'h7;
    localparam logic [3:0]  LEN_ONE     = 4'h1;
    localparam logic [3:0]  IDX_SC_EOT  = 4'h6;
    localparam int          BUF_DEPTH   = 10;
    // Field positions of command bytes
    localparam int          B_LOCK      = 7;
    localparam int          B_OW        = 7;
    localparam int          B_HEAD      = 2;
    localparam int          B_MFM       = 6;
    // ********************************************************
    // Types
    // ********************************************************
    typedef enum logic [2:0] {
        K_DUMP, K_RDID, K_PERP, K_LOCK, K_OTHER, K_BAD
    } fdcm_kind_t;
    typedef enum logic [4:0] {
        S_IDLE   = 5'b00001,
        S_PARAM  = 5'b00010,
        S_SEARCH = 5'b00100,
        S_LOAD   = 5'b01000,
        S_RESULT = 5'b10000
    } fdcm_state_t;

    function automatic fdcm_kind_t fdcm_decode(input logic [7:0] op);
        fdcm_kind_t k;
        k = K_BAD;
        if (op == OP_DUMP) begin
            k = K_DUMP;
        end else if (op[4:0] == OP_RDID) begin
            k = K_RDID;
        end else if (op == OP_PERP) begin
            k = K_PERP;
        end else if (op[4:0] == OP_LOCK) begin
            k = K_LOCK;
        end else begin
            unique case (op[4:0])
                5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
                5'h09, 5'h0C, 5'h0D, 5'h0F, 5'h10, 5'h11, 5'h13,
                5'h16, 5'h19, 5'h1D: k = K_OTHER;
                default: k = K_BAD;
            endcase
        end
        return k;
    endfunction
endpackage

// ==== hw/fdcm_rbuf.sv ====
`timescale 1ns/1ps
module fdcm_rbuf
    import fdcm_pkg::*;
(
    input  wire logic CLOCK_I,
    fdcm_rbuf_if.mem  bus
);
    // ********************************************************
    // Result byte store, registered read
    // ********************************************************
    logic [7:0] mem_q [BUF_DEPTH];
    logic [7:0] rd_q;

    always_ff @(posedge CLOCK_I) begin
        if (bus.wr_en) begin
            mem_q[bus.wr_addr] <= bus.wr_data;
        end
        rd_q <= mem_q[bus.rd_addr];
    end
    assign bus.rd_data = rd_q;
endmodule

// ==== hw/fdcm_rbuf_if.sv ====
`timescale 1ns/1ps
interface fdcm_rbuf_if;
    logic       wr_en;
    logic [3:0] wr_addr;
    logic [7:0] wr_data;
    logic [3:0] rd_addr;
    logic [7:0] rd_data;
    modport ctrl (output wr_en, output wr_addr, output wr_data,
                  output rd_addr, input rd_data);
    modport mem  (input wr_en, input wr_addr, input wr_data,
                  input rd_addr, output rd_data);
endinterface

// ==== hw/fdcm_top.sv ====
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Notes on behaviour
// (RULE_01) Read-ID keeps first error-free ID field
// (RULE_02) Read-ID returns three status, then C H R N
// (RULE_03) Unknown opcode: standby, one result byte 80H
// (RULE_04) Dump byte six: sectors value after format
// (RULE_05) Dump byte six: end of track otherwise
// (RULE_06) Perpendicular drive bits stay internal only
// (RULE_07) Software keeps those bits matching drive select
// (RULE_08) Dump places ten parameter bytes for reading
module fdcm_top
    import fdcm_pkg::*;
(
    // Clock and reset
    input  wire logic        CLOCK_I,
    input  wire logic        RST_N_I,
    // AXI4-Lite slave
    input  wire logic        AWVALID_I,
    output logic             AWREADY_O,
    input  wire logic [3:0]  AWADDR_I,
    input  wire logic        WVALID_I,
    output logic             WREADY_O,
    input  wire logic [31:0] WDATA_I,
    input  wire logic [3:0]  WSTRB_I,
    output logic             BVALID_O,
    input  wire logic        BREADY_I,
    output logic [1:0]       BRESP_O,
    input  wire logic        ARVALID_I,
    output logic             ARREADY_O,
    input  wire logic [3:0]  ARADDR_I,
    output logic             RVALID_O,
    input  wire logic        RREADY_I,
    output logic [31:0]      RDATA_O,
    output logic [1:0]       RRESP_O,
    // Parameters held by other command blocks
    input  wire logic [31:0] PRESENT_CYLINDER_NUMBER_I,
    input  wire logic [3:0]  STEP_RATE_TIME_I,
    input  wire logic [3:0]  HEAD_UNLOAD_TIME_I,
    input  wire logic [6:0]  HEAD_LOAD_TIME_I,
    input  wire logic        PIO_TRANSFER_MODE_I,
    input  wire logic [7:0]  SECTORS_PER_CYLINDER_I,
    input  wire logic [7:0]  END_OF_TRACK_I,
    input  wire logic        LAST_WAS_FORMAT_I,
    input  wire logic [7:0]  CONFIG_BITS_I,
    input  wire logic [7:0]  PRECOMP_START_TRACK_I,
    // ID search engine
    output logic             SEARCH_REQ_O,
    output logic             SEARCH_MFM_O,
    output logic             HEAD_SELECT_O,
    output logic [1:0]       SEARCH_DRIVE_O,
    input  wire logic        ID_VALID_I,
    input  wire logic        ID_OK_I,
    input  wire logic        SEARCH_FAIL_I,
    input  wire logic [31:0] ID_CHRN_I,
    input  wire logic [23:0] RESULT_STATUS_I,
    // Held configuration
    output logic [3:0]       PERP_DRIVES_O,
    output logic             PERP_GAP_O,
    output logic             WRITE_GATE_EARLY_TIMING_O,
    output logic             LOCK_O,
    output logic             STANDBY_O
);
    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        fdcm_state_t st;
        fdcm_kind_t  kind;
        logic        aw_got;
        logic        w_got;
        logic [3:0]  awaddr;
        logic [7:0]  wdata;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [7:0]  rdata;
        logic [3:0]  cnt;
        logic [3:0]  len;
        logic        lock;
        logic [3:0]  perp;
        logic        gap;
        logic        write_gate_early_timing;
        logic        standby;
        logic        mfm;
        logic        head;
        logic [1:0]  drive;
        logic [55:0] idres;
    } fdcm_regs_t;

    fdcm_regs_t  q;
    fdcm_regs_t  d;
    fdcm_rbuf_if rb ();
    logic [7:0]  res_byte [BUF_DEPTH];
    logic        wr_fire;
    logic        cmd_take;
    logic        perp_upd;

    fdcm_rbuf u_rbuf (
        .CLOCK_I (CLOCK_I),
        .bus     (rb.mem)
    );

    // ********************************************************
    // Result bytes
    // ********************************************************
    always_comb begin
        for (int i = 0; i < BUF_DEPTH; i++) begin
            res_byte[i] = 8'h00;
        end
        unique case (q.kind)
            K_DUMP: begin // RULE_08
                for (int i = 0; i < 4; i++) begin
                    res_byte[i] = PRESENT_CYLINDER_NUMBER_I[8*i +: 8];
                end
                res_byte[4] = {STEP_RATE_TIME_I, HEAD_UNLOAD_TIME_I};
                res_byte[5] = {HEAD_LOAD_TIME_I, PIO_TRANSFER_MODE_I};
                res_byte[IDX_SC_EOT] = END_OF_TRACK_I; // RULE_05
                if (LAST_WAS_FORMAT_I) begin
                    res_byte[IDX_SC_EOT] = SECTORS_PER_CYLINDER_I; // RULE_04
                end
                res_byte[7] = {q.lock, 1'b0, q.perp, q.gap, q.write_gate_early_timing};
                res_byte[8] = {1'b0, CONFIG_BITS_I[6:0]};
                res_byte[9] = PRECOMP_START_TRACK_I; // RULE_08
            end
            K_RDID: begin
                for (int i = 0; i < 7; i++) begin
                    res_byte[i] = q.idres[8*i +: 8]; // RULE_02
                end
            end
            K_LOCK: res_byte[0] = {3'h0, q.lock, 4'h0};
            K_BAD: res_byte[0] = RES_INVALID; // RULE_03
            default: res_byte[0] = 8'h00;
        endcase
    end

    // ********************************************************
    // Next state
    // ********************************************************
    assign wr_fire  = q.aw_got && q.w_got && !q.bvalid;
    assign cmd_take = wr_fire && q.awaddr == ADDR_DATA
                      && (q.st == S_IDLE || q.st == S_PARAM);
    assign perp_upd = cmd_take && q.st == S_PARAM && q.kind == K_PERP
                      && q.wdata[B_OW];

    always_comb begin
        d = q;
        if (AWVALID_I && AWREADY_O) begin
            d.aw_got = 1'b1;
            d.awaddr = AWADDR_I;
        end
        if (WVALID_I && WREADY_O) begin
            d.w_got = 1'b1;
            d.wdata = WSTRB_I[0] ? WDATA_I[7:0] : 8'h00;
        end
        if (BVALID_O && BREADY_I) begin
            d.bvalid = 1'b0;
        end
        if (RVALID_O && RREADY_I) begin
            d.rvalid = 1'b0;
        end
        if (wr_fire) begin
            d.aw_got = 1'b0;
            d.w_got  = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = q.awaddr == ADDR_DATA ? RESP_OKAY : RESP_SLVERR;
        end
        if (ARVALID_I && ARREADY_O) begin
            d.rvalid = 1'b1;
            d.rresp  = RESP_OKAY;
            d.rdata  = 8'h00;
            unique case (ARADDR_I)
                ADDR_DATA: begin
                    if (q.st == S_RESULT) begin
                        d.rdata = rb.rd_data;
                        d.cnt   = q.cnt + 4'h1;
                        if (q.cnt == q.len - 4'h1) begin
                            d.st = S_IDLE;
                        end
                    end
                end
                ADDR_STATUS: d.rdata = {3'h0, q.st};
                ADDR_PERP: d.rdata = {q.lock, 1'b0, q.perp, q.gap, q.write_gate_early_timing};
                default: d.rresp = RESP_SLVERR;
            endcase
        end
        unique case (q.st)
            S_IDLE: begin
                if (cmd_take) begin
                    d.kind    = fdcm_decode(q.wdata);
                    d.standby = 1'b0;
                    d.cnt     = 4'h0;
                    d.len     = LEN_ONE;
                    unique case (fdcm_decode(q.wdata))
                        K_DUMP: begin
                            d.len = LEN_DUMP; // RULE_08
                            d.st  = S_LOAD;
                        end
                        K_RDID, K_PERP: begin
                            d.mfm = q.wdata[B_MFM];
                            d.st  = S_PARAM;
                        end
                        K_LOCK: begin
                            d.lock = q.wdata[B_LOCK];
                            d.st   = S_LOAD;
                        end
                        K_BAD: begin
                            d.standby = 1'b1; // RULE_03
                            d.st      = S_LOAD;
                        end
                        default: d.st = S_IDLE;
                    endcase
                end
            end
            S_PARAM: begin
                if (cmd_take && q.kind == K_PERP) begin
                    if (perp_upd) begin
                        d.perp = q.wdata[5:2]; // RULE_06
                    end
                    d.gap   = q.wdata[1];
                    d.write_gate_early_timing = q.wdata[0];
                    d.st    = S_IDLE;
                end else if (cmd_take) begin
                    d.head  = q.wdata[B_HEAD];
                    d.drive = q.wdata[1:0];
                    d.st    = S_SEARCH;
                end
            end
            S_SEARCH: begin
                // Bad ID fields are skipped; only the first good one counts
                if ((ID_VALID_I && ID_OK_I) || SEARCH_FAIL_I) begin
                    d.idres = {ID_CHRN_I, RESULT_STATUS_I}; // RULE_01
                    d.len   = LEN_RDID; // RULE_02
                    d.st    = S_LOAD;
                end
            end
            S_LOAD: begin
                d.cnt = q.cnt + 4'h1;
                if (q.cnt == q.len - 4'h1) begin
                    d.cnt = 4'h0;
                    d.st  = S_RESULT;
                end
            end
            S_RESULT: begin
            end
        endcase
    end

    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            q       <= '0;
            q.st    <= S_IDLE;
            q.kind  <= K_OTHER;
        end else begin
            q <= d;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign rb.wr_en   = q.st == S_LOAD;
    assign rb.wr_addr = q.cnt;
    assign rb.wr_data = res_byte[q.cnt];
    assign rb.rd_addr = q.cnt;

    // Single outstanding transfer per direction keeps the pop timing simple
    assign AWREADY_O = !q.aw_got && !q.bvalid;
    assign WREADY_O  = !q.w_got && !q.bvalid;
    assign BVALID_O  = q.bvalid;
    assign BRESP_O   = q.bresp;
    assign ARREADY_O = !q.rvalid;
    assign RVALID_O  = q.rvalid;
    assign RDATA_O   = {24'h000000, q.rdata};
    assign RRESP_O   = q.rresp;

    assign SEARCH_REQ_O   = q.st == S_SEARCH;
    assign SEARCH_MFM_O   = q.mfm;
    assign HEAD_SELECT_O  = q.head;
    assign SEARCH_DRIVE_O = q.drive;
    // No path from these bits to any drive select pin
    assign PERP_DRIVES_O  = q.perp; // RULE_06
    assign PERP_GAP_O     = q.gap;
    assign WRITE_GATE_EARLY_TIMING_O = q.write_gate_early_timing;
    assign LOCK_O         = q.lock;
    assign STANDBY_O      = q.standby;

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);

    sequence bad_cmd;
        cmd_take && q.st == S_IDLE && fdcm_decode(q.wdata) == K_BAD;
    endsequence

    a_invalid_byte: assert property (bad_cmd |=> rb.wr_en // RULE_03
        && rb.wr_data == RES_INVALID ##1 q.st == S_RESULT)
        else $error("invalid opcode result byte wrong");
    a_invalid_stby: assert property (bad_cmd |=> STANDBY_O) // RULE_03
        else $error("standby not entered");
    a_dump_len: assert property (cmd_take && q.st == S_IDLE // RULE_08
        && q.wdata == OP_DUMP |=> q.len == LEN_DUMP && q.st == S_LOAD)
        else $error("dump length wrong");
    a_rdid_done: assert property (q.st == S_SEARCH && ID_VALID_I // RULE_02
        && ID_OK_I |=> q.st == S_LOAD && q.len == LEN_RDID)
        else $error("read id completion wrong");
    a_rdid_skip: assert property (q.st == S_SEARCH && ID_VALID_I // RULE_01
        && !ID_OK_I && !SEARCH_FAIL_I |=> q.st == S_SEARCH)
        else $error("bad id field accepted");
    a_sc_select: assert property (rb.wr_en && q.kind == K_DUMP // RULE_04
        && q.cnt == IDX_SC_EOT && LAST_WAS_FORMAT_I
        |-> rb.wr_data == SECTORS_PER_CYLINDER_I)
        else $error("sectors value not returned");
    a_eot_select: assert property (rb.wr_en && q.kind == K_DUMP // RULE_05
        && q.cnt == IDX_SC_EOT && !LAST_WAS_FORMAT_I
        |-> rb.wr_data == END_OF_TRACK_I)
        else $error("end of track not returned");
    a_perp_hold: assert property (!$stable(PERP_DRIVES_O) // RULE_06
        |-> $past(perp_upd))
        else $error("perpendicular bits changed unexpectedly");
endmodule
